// *** verilog/drw_pkg.sv ***
// constants of the debug read/write access engine: register map, fields, states
// assumes a word-wide register port and a four-phase handshake to the memory bus
package drw_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_START_ADDR = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_EVT_STAT = 8'h0c;
    localparam logic [7:0] OFS_EVT_MASK = 8'h10;
    localparam logic [7:0] OFS_ENABLE = 8'h14;

    // ------------------------------------------------------------
    // control/status fields
    // ------------------------------------------------------------
    localparam int CS_START_BIT = 31;
    localparam int CS_WRITE_BIT = 30;
    localparam int CS_SIZE_LSB = 27;
    localparam int CS_SIZE_W = 3;
    localparam int CS_CNT_LSB = 2;
    localparam int CS_CNT_W = 14;
    localparam int CS_ERR_BIT = 2;
    localparam int CS_BUSY_BIT = 1;
    localparam int CS_READY_BIT = 0;
    localparam logic [2:0] SIZE_MAX = 3'h2;

    // event bits (status and mask share this layout)
    localparam int EVT_ACCESS_BIT = 0;
    localparam int EVT_BLOCK_BIT = 1;
    localparam int EVT_ERR_BIT = 2;
    localparam int EVT_W = 3;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [EVT_W-1:0] RST_EVT = 3'h0;
    localparam logic [CS_CNT_W-1:0] RST_CNT = 14'h0000;
    localparam logic [CS_SIZE_W-1:0] RST_SIZE = 3'h2;

    // ------------------------------------------------------------
    // engine states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_ISSUE = 5'b00010,
        S_REQ = 5'b00100,
        S_REL = 5'b01000,
        S_WAIT = 5'b10000
    } drw_state_t;

endpackage

// *** verilog/drw_sync.sv ***
// two-flop synchroniser for a bundle of inputs from outside the core clock
// assumes multi-bit members are held stable while their qualifier is seen
module drw_sync #(
    parameter int W = 1
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule

// *** verilog/drw_engine.sv ***
// debug read/write access engine: register port for the debug tool, memory master
// assumes the memory side answers a level request with a level acknowledge on its own clock
//
// Our own choices: the strobed register port and the register offsets.

// How it works
// RQ1: engine accesses go straight to the memory bus, marked uncached and never through the address translator.
// RQ2: the programmed address is put on the bus unchanged as a physical address.
// RQ3: the engine is its own bus master and never asks the processor to stop.
// RQ4: reads return whatever memory holds, as the bus answers it.
// RQ5: writes go to memory only and nothing is sent to update or invalidate a cache.
// RQ6: the tool loads start address, word size and count before a transfer.
// RQ7: the tool enables access first and only then writes the start address.
// RQ8: for writes the tool loads the data after the address and before the control word.
// RQ9: writing the control word with size and count, start bit set, launches the transfer.
// RQ10: the ready pin goes high when each single access of a block has completed.
// RQ11: ready, busy and error show in the control/status register for polling.
// RQ12: after each access the address steps by the size, and after the count the engine reports done.
module drw_engine (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    input wire logic i_link_clk,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_wdata,
    output logic [2:0] o_mem_size,
    output logic o_mem_uncached,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    output logic o_ready,
    output logic o_irq
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic size_ok(input logic [2:0] size_code);
        size_ok = (size_code <= drw_pkg::SIZE_MAX);
    endfunction

    function automatic logic [31:0] size_step(input logic [2:0] size_code);
        size_step = 32'h0000_0001 << size_code[1:0];
    endfunction

    // ------------------------------------------------------------
    // synchronised inputs
    // ------------------------------------------------------------
    logic [33:0] sync_w;
    logic link_s;
    logic ack_s;
    logic [31:0] rdata_s;
    logic link_d_r;
    logic link_fall;

    drw_sync #(.W(34)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async({i_link_clk, i_mem_ack, i_mem_rdata}),
        .o_sync(sync_w)
    );

    assign link_s = sync_w[33];
    assign ack_s = sync_w[32];
    assign rdata_s = sync_w[31:0];
    // requests move on the link's falling edge so the far side samples a settled bus
    assign link_fall = link_d_r & ~link_s;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    drw_pkg::drw_state_t st_r, st_nxt;
    logic [31:0] addr_r;
    logic [31:0] data_r;
    logic [31:0] cur_addr_r;
    logic [2:0] size_r;
    logic write_r;
    logic [13:0] cnt_r;
    logic [13:0] remain_r;
    logic done_r;
    logic err_r;
    logic enable_r;
    logic [2:0] evt_stat_r;
    logic [2:0] evt_mask_r;
    logic [31:0] rdata_r;
    logic req_r;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire hit_addr = i_reg_addr == drw_pkg::OFS_START_ADDR;
    wire hit_data = i_reg_addr == drw_pkg::OFS_DATA;
    wire hit_ctrl = i_reg_addr == drw_pkg::OFS_CTRL;
    wire hit_stat = i_reg_addr == drw_pkg::OFS_EVT_STAT;
    wire hit_mask = i_reg_addr == drw_pkg::OFS_EVT_MASK;
    wire hit_en = i_reg_addr == drw_pkg::OFS_ENABLE;
    wire busy = st_r != drw_pkg::S_IDLE;
    wire [2:0] wr_size = i_reg_wdata[drw_pkg::CS_SIZE_LSB +: drw_pkg::CS_SIZE_W];
    wire [13:0] wr_cnt = i_reg_wdata[drw_pkg::CS_CNT_LSB +: drw_pkg::CS_CNT_W];
    wire ctrl_wr = i_reg_wr & hit_ctrl;
    wire start_req = ctrl_wr & i_reg_wdata[drw_pkg::CS_START_BIT];
    // a start while disabled, busy or with an unsupported size is refused and flagged
    wire start_ok = start_req & enable_r & ~busy & size_ok(wr_size);
    wire start_bad = start_req & ~start_ok;
    // next access of a block is released by the tool reading or refilling the data word
    wire data_touch = hit_data & (write_r ? i_reg_wr : i_reg_rd);
    wire ack_take = (st_r == drw_pkg::S_REQ) & ack_s;
    wire access_end = (st_r == drw_pkg::S_REL) & ~ack_s & ~req_r;
    wire last_access = remain_r == 14'h0001;
    wire [2:0] evt_set = {start_bad, access_end & last_access, access_end};
    // count reads back one place up, since bit 2 of the view carries the error flag
    wire [31:0] ctrl_view = {1'b0, write_r, size_r, 10'h000, cnt_r, err_r, busy, o_ready};

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            drw_pkg::S_IDLE: begin
                if (start_ok) begin
                    st_nxt = drw_pkg::S_ISSUE; // RQ9
                end
            end
            drw_pkg::S_ISSUE: begin
                if (link_fall) begin
                    st_nxt = drw_pkg::S_REQ;
                end
            end
            drw_pkg::S_REQ: begin
                if (ack_s) begin
                    st_nxt = drw_pkg::S_REL;
                end
            end
            drw_pkg::S_REL: begin
                if (access_end) begin
                    st_nxt = last_access ? drw_pkg::S_IDLE : drw_pkg::S_WAIT; // RQ12
                end
            end
            drw_pkg::S_WAIT: begin
                if (data_touch) begin
                    st_nxt = drw_pkg::S_ISSUE;
                end
            end
            default: st_nxt = drw_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= drw_pkg::S_IDLE;
            link_d_r <= 1'b0;
            req_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            link_d_r <= link_s;
            // request only ever changes on a link falling edge
            if (link_fall) begin
                req_r <= (st_r == drw_pkg::S_ISSUE) | (st_r == drw_pkg::S_REQ); // RQ3
            end
        end
    end

    // ------------------------------------------------------------
    // transfer registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            addr_r <= drw_pkg::RST_WORD;
            cur_addr_r <= drw_pkg::RST_WORD;
            size_r <= drw_pkg::RST_SIZE;
            write_r <= 1'b0;
            cnt_r <= drw_pkg::RST_CNT;
            remain_r <= drw_pkg::RST_CNT;
            enable_r <= 1'b0;
        end else begin
            if (i_reg_wr & hit_en) begin
                enable_r <= i_reg_wdata[0];
            end
            if (i_reg_wr & hit_addr & ~busy) begin
                addr_r <= i_reg_wdata;
            end
            if (start_ok) begin
                size_r <= wr_size;
                write_r <= i_reg_wdata[drw_pkg::CS_WRITE_BIT];
                cnt_r <= wr_cnt;
                remain_r <= (wr_cnt == 14'h0000) ? 14'h0001 : wr_cnt;
                cur_addr_r <= addr_r; // RQ2
            end else if (access_end) begin
                remain_r <= remain_r - 14'h0001; // RQ12
                cur_addr_r <= cur_addr_r + size_step(size_r); // RQ12
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            data_r <= drw_pkg::RST_WORD;
        end else if (ack_take & ~write_r) begin
            data_r <= rdata_s; // RQ4
        end else if (i_reg_wr & hit_data & (~busy | (st_r == drw_pkg::S_WAIT))) begin
            data_r <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            done_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            if (start_ok) begin
                done_r <= 1'b0;
            end else if (access_end) begin
                done_r <= 1'b1; // RQ10
            end else if (st_nxt == drw_pkg::S_ISSUE) begin
                done_r <= 1'b0;
            end
            if (start_bad) begin
                err_r <= 1'b1;
            end else if (start_ok) begin
                err_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // events and register read port
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            evt_stat_r <= drw_pkg::RST_EVT;
            evt_mask_r <= drw_pkg::RST_EVT;
            rdata_r <= drw_pkg::RST_WORD;
        end else begin
            // a new event in the reading cycle survives the clear
            evt_stat_r <= ((i_reg_rd & hit_stat) ? drw_pkg::RST_EVT : evt_stat_r) | evt_set;
            if (i_reg_wr & hit_mask) begin
                evt_mask_r <= i_reg_wdata[2:0];
            end
            if (!i_reg_rd) begin
                rdata_r <= drw_pkg::RST_WORD;
            end else if (hit_addr) begin
                rdata_r <= addr_r;
            end else if (hit_data) begin
                rdata_r <= data_r;
            end else if (hit_ctrl) begin
                rdata_r <= ctrl_view; // RQ11
            end else if (hit_stat) begin
                rdata_r <= {29'h0, evt_stat_r};
            end else if (hit_mask) begin
                rdata_r <= {29'h0, evt_mask_r};
            end else if (hit_en) begin
                rdata_r <= {31'h0, enable_r};
            end else begin
                rdata_r <= drw_pkg::RST_WORD;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_reg_rdata = rdata_r;
    assign o_mem_req = req_r;
    assign o_mem_we = write_r; // RQ5
    assign o_mem_addr = cur_addr_r; // RQ2
    assign o_mem_wdata = data_r;
    assign o_mem_size = size_r;
    // no cache or translator port exists on this path at all
    assign o_mem_uncached = 1'b1; // RQ1
    assign o_ready = done_r & ((st_r == drw_pkg::S_WAIT) | (st_r == drw_pkg::S_IDLE)); // RQ10
    assign o_irq = |(evt_stat_r & evt_mask_r);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_uncached;
        @(posedge i_core_clk) disable iff (i_rst) o_mem_req |-> o_mem_uncached;
    endproperty
    a_uncached: assert property (p_uncached) else $error("uncached attribute dropped"); // RQ1

    property p_addr_hold;
        @(posedge i_core_clk) disable iff (i_rst) o_mem_req && $past(o_mem_req) |-> $stable(o_mem_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved during request"); // RQ2

    property p_req_on_fall;
        @(posedge i_core_clk) disable iff (i_rst) $rose(o_mem_req) |-> $past(link_fall);
    endproperty
    a_req_on_fall: assert property (p_req_on_fall) else $error("request not on link fall"); // RQ3

    property p_read_capture;
        @(posedge i_core_clk) disable iff (i_rst) ack_take && !write_r |=> data_r == $past(rdata_s);
    endproperty
    a_read_capture: assert property (p_read_capture) else $error("read data not captured"); // RQ4

    property p_write_data;
        @(posedge i_core_clk) disable iff (i_rst)
            o_mem_req && $past(o_mem_req) && o_mem_we |-> $stable(o_mem_wdata) && $stable(o_mem_we);
    endproperty
    a_write_data: assert property (p_write_data) else $error("write bus wrong"); // RQ5

    property p_start;
        @(posedge i_core_clk) disable iff (i_rst)
            start_ok |=> st_r == drw_pkg::S_ISSUE && cur_addr_r == $past(addr_r) && size_r == $past(wr_size);
    endproperty
    a_start: assert property (p_start) else $error("start not taken"); // RQ9

    property p_ready_rise;
        @(posedge i_core_clk) disable iff (i_rst) $rose(o_ready) |-> $past(access_end);
    endproperty
    a_ready_rise: assert property (p_ready_rise) else $error("ready without access end"); // RQ10

    property p_ctrl_view;
        @(posedge i_core_clk) disable iff (i_rst)
            i_reg_rd && hit_ctrl |=> o_reg_rdata[0] == $past(o_ready) && o_reg_rdata[1] == $past(busy);
    endproperty
    a_ctrl_view: assert property (p_ctrl_view) else $error("status view wrong"); // RQ11

    property p_step;
        @(posedge i_core_clk) disable iff (i_rst)
            access_end |=> cur_addr_r == $past(cur_addr_r) + size_step($past(size_r))
                && remain_r == $past(remain_r) - 14'h0001;
    endproperty
    a_step: assert property (p_step) else $error("address or count step wrong"); // RQ12

    c_block: cover property (@(posedge i_core_clk) disable iff (i_rst)
        st_r == drw_pkg::S_WAIT ##1 st_r == drw_pkg::S_ISSUE);
    c_done: cover property (@(posedge i_core_clk) disable iff (i_rst) access_end && last_access);
    c_refused: cover property (@(posedge i_core_clk) disable iff (i_rst) start_bad);

endmodule

// *** test/drw_mem_model.sv ***
// memory-side partner of the debug access engine: answers the four-phase handshake
// assumes the bench supplies the free-running link clock and the shared reset
module drw_mem_model (
    input wire logic i_link_clk,
    input wire logic i_rst,
    input wire logic i_slow,
    input wire logic i_mem_req,
    input wire logic i_mem_we,
    input wire logic [31:0] i_mem_addr,
    input wire logic [31:0] i_mem_wdata,
    input wire logic [2:0] i_mem_size,
    input wire logic i_mem_uncached,
    output logic o_mem_ack,
    output logic [31:0] o_mem_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // handshake and access log
    // ------------------------------------------------------------
    int n_acc;
    logic [2:0] wait_r;
    logic data_ok_r;
    logic [31:0] last_addr;
    logic [31:0] last_wdata;
    logic [2:0] last_size;
    logic last_we;
    logic last_unc;

    always @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mem_ack <= 1'b0;
            o_mem_rdata <= 32'h0000_0000;
            wait_r <= 3'h0;
            data_ok_r <= 1'b0;
            n_acc <= 0;
        end else if (i_mem_req && !o_mem_ack) begin
            if (wait_r < (i_slow ? 3'h4 : 3'h0)) begin
                wait_r <= wait_r + 3'h1;
            end else if (!data_ok_r) begin
                // data settle one link cycle before ack rises
                o_mem_rdata <= {i_mem_addr[15:0] ^ 16'h5a5a, i_mem_addr[15:0]};
                data_ok_r <= 1'b1;
            end else begin
                o_mem_ack <= 1'b1;
                n_acc <= n_acc + 1;
                last_addr <= i_mem_addr;
                last_wdata <= i_mem_wdata;
                last_size <= i_mem_size;
                last_we <= i_mem_we;
                last_unc <= i_mem_uncached;
            end
        end else if (!i_mem_req && o_mem_ack) begin
            // released bus shows the inverse, never the stale word
            o_mem_ack <= 1'b0;
            o_mem_rdata <= ~o_mem_rdata;
            wait_r <= 3'h0;
            data_ok_r <= 1'b0;
        end
    end
endmodule

// *** test/debug_memory_rw_access_tb.sv ***
// self-checking bench of the debug access engine with a memory partner model
// assumes drw_pkg, drw_sync and drw_engine compiled before this file
module debug_memory_rw_access_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk, link_clk, rst, wr, rd, slow;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, mem_addr, mem_wdata, mem_rdata, rnd;
    logic mem_req, mem_we, mem_unc, mem_ack, ready, irq;
    logic [2:0] mem_size;
    logic [31:0] r;
    int errors, n_checks, i;
    logic [7:0] zero_ofs [5];

    drw_engine dut (.i_core_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
        .i_reg_rd(rd), .o_reg_rdata(rdata), .i_link_clk(link_clk), .o_mem_req(mem_req), .o_mem_we(mem_we),
        .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .o_mem_size(mem_size), .o_mem_uncached(mem_unc),
        .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_ready(ready), .o_irq(irq));
    drw_mem_model u_mem (.i_link_clk(link_clk), .i_rst(rst), .i_slow(slow), .i_mem_req(mem_req),
        .i_mem_we(mem_we), .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata), .i_mem_size(mem_size),
        .i_mem_uncached(mem_unc), .o_mem_ack(mem_ack), .o_mem_rdata(mem_rdata));

    // ------------------------------------------------------------
    // clocks, helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #7.3;
        forever #62.5 link_clk = ~link_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    endfunction
    function automatic logic [31:0] mem_word(input logic [31:0] a);
        return {a[15:0] ^ 16'h5a5a, a[15:0]};
    endfunction
    function automatic logic [31:0] ctrl_word(input logic we, input logic [2:0] size_code, input logic [13:0] cnt);
        return (32'h1 << drw_pkg::CS_START_BIT) | ({31'h0, we} << drw_pkg::CS_WRITE_BIT)
            | ({29'h0, size_code} << drw_pkg::CS_SIZE_LSB) | ({18'h0, cnt} << drw_pkg::CS_CNT_LSB);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic settle();
        @(posedge clk);
        #1;
    endtask
    task automatic wait_acc(input int target);
        int k;
        for (k = 0; k < 4000 && !(u_mem.n_acc == target && ready === 1'b1); k++) settle();
        chk({31'h0, ready}, 32'h1);
    endtask

    // one block: setup order address, data (write blocks only), control; then one access per ready
    task automatic do_block(input logic we, input logic [2:0] size_code, input logic [13:0] cnt, input logic sl);
        logic [31:0] base, d, q;
        int n, n0, k;
        slow <= sl;
        rnd = lfsr_next(rnd);
        base = rnd & 32'h0000_fff0;
        rnd = lfsr_next(rnd);
        d = rnd;
        n = (cnt == 14'h0) ? 1 : int'(cnt);
        n0 = u_mem.n_acc;
        reg_wr(drw_pkg::OFS_START_ADDR, base);
        if (we) reg_wr(drw_pkg::OFS_DATA, d);
        reg_wr(drw_pkg::OFS_CTRL, ctrl_word(we, size_code, cnt));
        reg_rd(drw_pkg::OFS_CTRL, q);
        chk(q & 32'h3, 32'h2);
        for (k = 0; k < n; k++) begin
            wait_acc(n0 + k + 1);
            chk(u_mem.last_addr, base + (32'h1 << size_code) * k);
            chk({29'h0, u_mem.last_size}, {29'h0, size_code});
            chk({30'h0, u_mem.last_unc, u_mem.last_we}, {30'h0, 1'b1, we});
            if (we) begin
                chk(u_mem.last_wdata, d);
                rnd = lfsr_next(rnd);
                d = rnd;
                if (k < n - 1) reg_wr(drw_pkg::OFS_DATA, d);
            end else begin
                reg_rd(drw_pkg::OFS_DATA, q);
                chk(q, mem_word(base + (32'h1 << size_code) * k));
            end
        end
        reg_rd(drw_pkg::OFS_CTRL, q);
        chk(q & 32'h3, 32'h1);
        chk(u_mem.n_acc - n0, n);
        chk({31'h0, irq}, 32'h1);
        reg_rd(drw_pkg::OFS_EVT_STAT, q);
        chk(q, 32'h3);
        settle();
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic finish_test();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        #300000;
        errors++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        slow = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        rnd = 32'h0000_0035;
        zero_ofs = '{drw_pkg::OFS_START_ADDR, drw_pkg::OFS_DATA, drw_pkg::OFS_EVT_STAT,
            drw_pkg::OFS_EVT_MASK, 8'h20};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk({mem_unc, mem_req, ready, irq}, 4'h8);
        chk({29'h0, mem_size}, 32'h2);
        for (i = 0; i < 5; i++) begin
            reg_rd(zero_ofs[i], r);
            chk(r, 32'h0);
        end
        // start refused while access is disabled, event masked
        reg_wr(drw_pkg::OFS_CTRL, ctrl_word(1'b0, 3'h2, 14'h1));
        reg_rd(drw_pkg::OFS_CTRL, r);
        chk(r & 32'h4, 32'h4);
        chk({31'h0, irq}, 32'h0);
        reg_rd(drw_pkg::OFS_EVT_STAT, r);
        chk(r, 32'h4);
        // size beyond a word refused, now unmasked
        reg_wr(drw_pkg::OFS_EVT_MASK, 32'h4);
        reg_wr(drw_pkg::OFS_ENABLE, 32'h1);
        reg_wr(drw_pkg::OFS_CTRL, ctrl_word(1'b1, 3'h3, 14'h1));
        settle();
        chk({31'h0, irq}, 32'h1);
        reg_rd(drw_pkg::OFS_EVT_STAT, r);
        chk(r, 32'h4);
        settle();
        chk({31'h0, irq}, 32'h0);
        chk(u_mem.n_acc, 0);
        reg_wr(drw_pkg::OFS_EVT_MASK, 32'h2);
        for (i = 0; i < 3; i++) do_block(1'b1, i[2:0], 14'h3, i[0]);
        do_block(1'b0, 3'h2, 14'h0, 1'b0);
        do_block(1'b0, 3'h1, 14'h2, 1'b1);
        finish_test();
    end
endmodule
